// ==== shared/nv_seq_pkg.sv ====
// Constants, types and register map for the emulated nonvolatile access sequencer
// Summary of operation
// [R1] Top control bits pick erase time 2-16 ms
// [R2] Same time selection applies to write cycles
// [R3] Software sets erase enable, then erase trigger
// [R4] Erase trigger stays high until erase ends
// [R5] Software loads address/data, enable then write trigger
// [R6] Write trigger stays high until write ends
// [R7] Software loads address, read enable, read trigger
// [R8] Read trigger clears once data pair loaded
// [R9] Writing zero control disables further reads
// [R10] Each read needs address rewritten, no increment
// [R11] Software masks interrupts around activation pair
// [R12] Processor stalled while any cycle runs
// [R13] Erase clears 16-word page chosen by bit 4
// [R14] Erase and write enables auto-clear, read enable stays set; trigger without enable ignored
// [R15] Triggers refused while a cycle runs
package nv_seq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_DATA_LO = 8'h08;
  localparam logic [7:0] OFS_DATA_HI = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_TIME_HI = 7;
  localparam int CTL_TIME_LO = 6;
  localparam int CTL_ERASE_EN = 5;
  localparam int CTL_ERASE_TRIG = 4;
  localparam int CTL_WRITE_EN = 3;
  localparam int CTL_WRITE_TRIG = 2;
  localparam int CTL_READ_EN = 1;
  localparam int CTL_READ_TRIG = 0;
  localparam int PAGE_BIT = 4;

  // Interrupt status bit positions
  localparam int IRQ_ERASE = 0;
  localparam int IRQ_WRITE = 1;
  localparam int IRQ_READ = 2;

  // ----------------------------------------------------------------
  // Sizes, reset values and timing
  // ----------------------------------------------------------------
  localparam int MEM_WORDS = 32;
  localparam int WORD_W = 14;
  localparam int CNT_W = 20;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam int CLK_HZ = 10_000_000;
  localparam int BASE_TIME_MS = 2;
  localparam int BASE_CYCLES_DEF = BASE_TIME_MS * (CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] READ_CYCLES = 20'h00002;

  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_READ} op_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [7:0] dlo;
    logic [5:0] dhi;
    logic [MEM_WORDS-1:0][WORD_W-1:0] mem;
    op_e op;
    logic [CNT_W-1:0] cnt;
    logic [2:0] ist;
    logic [2:0] ien;
    logic ph_wr;
    logic [31:0] rdata;
    logic [7:0] ph_addr;
  } state_s;

endpackage : nv_seq_pkg

// ==== logic/nv_seq.sv ====
// Emulated nonvolatile access sequencer with AHB-Lite register slave
`timescale 1ns/100ps
module nv_seq
  import nv_seq_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYCLES_DEF
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor and interrupt
  output logic cpu_stall,
  output logic irq
);

  state_s state_reg;
  state_s state_next;
  logic [CNT_W-1:0] dur;
  logic [7:0] wd;
  logic idle;
  logic [2:0] done;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wd = hwdata[7:0];
    idle = (state_reg.op == OP_IDLE);
    done = 3'h0;
    // Time select scales the base 2 ms count by 1, 2, 4 or 8
    dur = CNT_W'(BASE_CYCLES) << state_reg.ctrl[CTL_TIME_HI:CTL_TIME_LO]; // [R1] [R2]

    // Address phase capture; writes are taken for full words only
    state_next.ph_wr = hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
    if (hsel && htrans[1] && hready)
    begin
      state_next.ph_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
    end

    // Running cycle
    if (!idle)
    begin
      if (state_reg.cnt == 20'h00001)
      begin
        state_next.op = OP_IDLE;
        unique case (state_reg.op)
          OP_ERASE:
          begin
            for (int i = 0; i < MEM_WORDS; i++)
            begin
              if (i[PAGE_BIT] == state_reg.addr[PAGE_BIT])
              begin
                state_next.mem[i] = '0; // [R13]
              end
            end
            state_next.ctrl[CTL_ERASE_TRIG] = 1'b0; // [R4]
            state_next.ctrl[CTL_ERASE_EN] = 1'b0; // [R14]
            done[IRQ_ERASE] = 1'b1;
          end
          OP_WRITE:
          begin
            state_next.mem[state_reg.addr[4:0]] = {state_reg.dhi, state_reg.dlo};
            state_next.ctrl[CTL_WRITE_TRIG] = 1'b0; // [R6]
            state_next.ctrl[CTL_WRITE_EN] = 1'b0; // [R14]
            done[IRQ_WRITE] = 1'b1;
          end
          OP_READ:
          begin
            // Fetched word lands in the pair as the trigger drops
            {state_next.dhi, state_next.dlo} = state_reg.mem[state_reg.addr[4:0]]; // [R8]
            state_next.ctrl[CTL_READ_TRIG] = 1'b0; // [R8]
            done[IRQ_READ] = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
      else
      begin
        state_next.cnt = state_reg.cnt - 20'h00001;
      end
    end

    // Register writes; control, address and data are frozen while a cycle runs, interrupt clear and enable are not
    if (state_reg.ph_wr)
    begin
      unique case (state_reg.ph_addr)
        OFS_CONTROL:
        begin
          if (idle) // [R15]
          begin
            // Zero write drops read enable as well [R9]
            state_next.ctrl = wd & ~8'h15;
            // Trigger needs its enable already set, so enable must come first
            if (wd[CTL_ERASE_TRIG] && state_reg.ctrl[CTL_ERASE_EN] && wd[CTL_ERASE_EN]) // [R14]
            begin
              state_next.ctrl[CTL_ERASE_TRIG] = 1'b1;
              state_next.op = OP_ERASE;
              state_next.cnt = dur; // [R1]
            end
            else if (wd[CTL_WRITE_TRIG] && state_reg.ctrl[CTL_WRITE_EN] && wd[CTL_WRITE_EN])
            begin
              state_next.ctrl[CTL_WRITE_TRIG] = 1'b1; // [R14]
              state_next.op = OP_WRITE;
              state_next.cnt = dur; // [R2]
            end
            else if (wd[CTL_READ_TRIG] && state_reg.ctrl[CTL_READ_EN] && wd[CTL_READ_EN])
            begin
              state_next.ctrl[CTL_READ_TRIG] = 1'b1; // [R14]
              state_next.op = OP_READ;
              state_next.cnt = READ_CYCLES;
            end
          end
        end
        OFS_ADDRESS:
        begin
          if (idle)
          begin
            state_next.addr = wd;
          end
        end
        OFS_DATA_LO:
        begin
          if (idle)
          begin
            state_next.dlo = wd;
          end
        end
        OFS_DATA_HI:
        begin
          if (idle)
          begin
            state_next.dhi = wd[5:0];
          end
        end
        OFS_IRQ_CLEAR: state_next.ist = state_reg.ist & ~hwdata[2:0];
        OFS_IRQ_ENABLE: state_next.ien = hwdata[2:0];
        default:
        begin
        end
      endcase
    end
    // Completion wins over a clear in the same cycle
    state_next.ist = state_next.ist | done;

    // Read data registered from what this edge loads, so a pipelined
    // read right behind a write still sees the new value
    state_next.rdata = 32'h0;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      unique case (state_next.ph_addr)
        OFS_CONTROL: state_next.rdata = {24'h0, state_next.ctrl};
        OFS_ADDRESS: state_next.rdata = {24'h0, state_next.addr};
        OFS_DATA_LO: state_next.rdata = {24'h0, state_next.dlo};
        OFS_DATA_HI: state_next.rdata = {26'h0, state_next.dhi};
        OFS_IRQ_STATUS: state_next.rdata = {29'h0, state_next.ist};
        OFS_IRQ_ENABLE: state_next.rdata = {29'h0, state_next.ien};
        default: state_next.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = state_reg.rdata;

  // Bus never waits so the stalled processor can still be modelled polling
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cpu_stall = (state_reg.op != OP_IDLE); // [R12]
  assign irq = |(state_reg.ist & state_reg.ien);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_stall_has_trigger: assert property (cpu_stall |-> // [R12]
    (state_reg.ctrl[4] | state_reg.ctrl[2] | state_reg.ctrl[0]))
    else $error("stall without active trigger");
  a_erase_needs_enable: assert property ($rose(state_reg.ctrl[4]) |-> // [R14]
    $past(state_reg.ctrl[5]))
    else $error("erase started without enable");
  a_erase_end_clears: assert property ($fell(state_reg.ctrl[4]) |-> // [R4]
    !state_reg.ctrl[5] && state_reg.ist[0] && !cpu_stall)
    else $error("erase end did not clear enable");
  a_write_end_clears: assert property ($fell(state_reg.ctrl[2]) |-> // [R6]
    !state_reg.ctrl[3] && state_reg.ist[1])
    else $error("write end did not clear enable");
  a_read_length: assert property ($rose(state_reg.ctrl[0]) |-> // [R8]
    state_reg.ctrl[0] [*2] ##1 !state_reg.ctrl[0])
    else $error("read cycle length wrong");
  a_read_data: assert property ($fell(state_reg.ctrl[0]) |-> // [R8]
    {state_reg.dhi, state_reg.dlo} == $past(state_reg.mem[state_reg.addr[4:0]]))
    else $error("read data not loaded");
  a_erase_min_time: assert property ($rose(state_reg.ctrl[4]) |-> // [R1]
    state_reg.ctrl[4] [*8])
    else $error("erase ended too early");
  a_single_op: assert property ($onehot0({state_reg.ctrl[4], // [R15]
    state_reg.ctrl[2], state_reg.ctrl[0]}))
    else $error("two cycles at once");
  a_busy_frozen: assert property (cpu_stall && !$rose(cpu_stall) |-> // [R15]
    $stable(state_reg.addr) && $stable(state_reg.ctrl[7:6]))
    else $error("registers changed mid cycle");

  c_erase: cover property ($fell(state_reg.ctrl[4]));
  c_write: cover property ($fell(state_reg.ctrl[2]));
  c_read: cover property ($fell(state_reg.ctrl[0]));
  c_irq: cover property ($rose(irq));

endmodule : nv_seq

// ==== tb/tb.sv ====
// Self-checking bench for the nonvolatile access sequencer
`timescale 1ns/100ps
module tb;
  import nv_seq_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int BASE = 10;
  localparam logic [7:0] EE = 8'h1 << CTL_ERASE_EN;
  localparam logic [7:0] ET = 8'h1 << CTL_ERASE_TRIG;
  localparam logic [7:0] WE = 8'h1 << CTL_WRITE_EN;
  localparam logic [7:0] WT = 8'h1 << CTL_WRITE_TRIG;
  localparam logic [7:0] RE = 8'h1 << CTL_READ_EN;
  localparam logic [7:0] RT = 8'h1 << CTL_READ_TRIG;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic cpu_stall;
  logic irq;
  logic [31:0] q;
  int errors = 0;
  int num_checks = 0;
  int n;

  always #50 hclk = ~hclk;

  // Short base count keeps the 16 ms case to 80 cycles
  nv_seq #(.BASE_CYCLES(BASE)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .cpu_stall(cpu_stall), .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr

  task rd(input logic [7:0] a, input string what, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, q, exp);
    chk("okay response", hresp, 32'h0);
  endtask : rd

  // Counts cycles until the stall drops; bounded so a hang still ends
  task wait_idle;
    #1;
    n = 0;
    while (cpu_stall === 1'b1 && n < 1000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask : wait_idle

  // Activation pair, trigger poll, refused retrigger, then timing
  task op(input logic [7:0] en, input logic [7:0] trig, input logic [1:0] sel);
    wr(OFS_IRQ_ENABLE, 8'h0);
    wr(OFS_CONTROL, {sel, 6'h0} | en);
    wr(OFS_CONTROL, {sel, 6'h0} | en | trig);
    wr(OFS_IRQ_ENABLE, 8'h2);
    rd(OFS_CONTROL, "trigger held", {24'h0, sel, 6'h0} | en | trig);
    wr(OFS_CONTROL, {sel, 6'h0} | WE | WT);
    wait_idle();
    chk("cycle length", n, (BASE << sel) - 6);
    rd(OFS_CONTROL, "enable cleared", {24'h0, sel, 6'h0});
  endtask : op

  task rd_word(input logic [7:0] a, input logic [13:0] exp);
    wr(OFS_ADDRESS, a);
    wr(OFS_CONTROL, RE);
    wr(OFS_CONTROL, RE | RT);
    wait_idle();
    chk("read length", n, 2);
    rd(OFS_CONTROL, "read done", {24'h0, RE});
    rd(OFS_DATA_LO, "data low", {24'h0, exp[7:0]});
    rd(OFS_DATA_HI, "data high", {26'h0, exp[13:8]});
  endtask : rd_word

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CONTROL, "control reset", 32'h0);
    rd(8'h40, "unmapped", 32'h0);
    wr(OFS_IRQ_ENABLE, 8'h2);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_ADDRESS, (k[0] ? 8'h10 : 8'h00) | 8'(k));
      wr(OFS_DATA_LO, 8'h50 + 8'(k));
      wr(OFS_DATA_HI, 8'h20 + 8'(k));
      op(WE, WT, k[1:0]);
      chk("write irq", irq, 1'b1);
      wr(OFS_IRQ_CLEAR, 8'h2);
      @(posedge hclk);
      chk("irq cleared", irq, 1'b0);
    end
    for (int k = 0; k < 4; k++)
      rd_word((k[0] ? 8'h10 : 8'h00) | 8'(k), {6'h20 + 6'(k), 8'h50 + 8'(k)});
    rd(OFS_IRQ_STATUS, "read status", 32'h4);
    chk("masked irq", irq, 1'b0);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL, "reads disabled", 32'h0);
    wr(OFS_CONTROL, RT);
    #1;
    chk("trigger no enable", cpu_stall, 1'b0);
    wr(OFS_ADDRESS, 8'h0f);
    for (int k = 0; k < 4; k++)
      op(EE, ET, k[1:0]);
    for (int k = 0; k < 4; k++)
      rd_word((k[0] ? 8'h10 : 8'h00) | 8'(k), k[0] ? {6'h20 + 6'(k), 8'h50 + 8'(k)} : 14'h0);
    rd(OFS_IRQ_STATUS, "erase status", 32'h5);
    test_done();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    test_done();
  end
endmodule : tb
